// ### inc/tph_pkg.sv
// constants and carrier types for the teaching pattern discrete I/O handshake
// assumes a single 20 MHz clock and a synchronous active-high reset
package tph_pkg;

   // clock rate and time figures
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned STORE_HOLD_MS = 20;            // store-here least hold time
   localparam int unsigned STORE_HOLD_CYC = (STORE_HOLD_MS * (CLK_HZ / 1000));
   localparam int unsigned NV_WRITE_CYC  = 64;            // modelled nonvolatile write time
   localparam int unsigned STEP_DIV_CYC  = 4;             // clocks per position step
   localparam int unsigned INCH_STEP     = 16;            // units per inching move
   localparam int unsigned INPOS_BAND    = 2;             // in-position band, units
   localparam int unsigned ZONE_HALF     = 8;             // zone half width set on store

   // widths and reset values
   localparam int unsigned IDX_W         = 6;
   localparam int unsigned POS_W         = 16;
   localparam logic [15:0] POS_RST       = 16'h0400;      // position after power-up
   localparam logic [5:0]  IDX_RST       = 6'h00;

   // discrete inputs from the controlling PLC
   typedef struct packed {
      logic [5:0] target_index;          // target_index_bit5..bit0
      logic       go_pulse;
      logic       home;
      logic       pause_n;
      logic       fault_clear;
      logic       drive_energize;
      logic       remote_manual_select;  // high selects manual
      logic       teach_select;          // high selects teaching
      logic       jog_step_select;       // high selects inching
      logic       jog_plus;
      logic       jog_minus;
      logic       store_here;
   } tph_in_t;

   // discrete outputs to the PLC
   typedef struct packed {
      logic [5:0] reached_index;         // reached_index_bit5..bit0
      logic       moving;
      logic       teach_state_out;
      logic       window_hit;
      logic       remote_manual_state;
      logic       homing_done;
      logic       arrival_flag;
      logic       store_done;
      logic       drive_prepared;
      logic       estop_n;
      logic       fault_n;
   } tph_out_t;

   // motion state
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_POS  = 3'b001,
      ST_HOME = 3'b010,
      ST_JOG  = 3'b011,
      ST_INCH = 3'b100
   } tph_state_t;

endpackage : tph_pkg

// ### design/tph_handshake.sv
// device side of the teaching pattern discrete I/O handshake with a motion model
// assumes inputs are asynchronous levels from the PLC; alarm and e-stop sources
// come from elsewhere in the controller as plain level inputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - teach select high means teaching mode
// - jog select low jogs, high inches
// - plus/minus rising edge starts jog or inch
// - remote select sets mode; state output follows
// - home rising edge starts homing sequence
// - pause low stops motion, high allows it
// - go rising edge starts move to target
// - store held 20 ms saves current position
// - fault clear rising edge clears alarm
// - servo energized exactly while energize high
// - reached index shows position on completion
// - reached index clears on next go
// - moving high only while actuator moves
// - teach state output high in teaching mode
// - window hit inside entry zone after command
// - homing done low from power-up until homed
// - arrival when target reached within band
// - store done after nonvolatile write finishes
// - prepared when energized and able to operate
// - estop output low during emergency stop
// - fault output low while any alarm
module tph_handshake #(
   parameter int unsigned STORE_HOLD = tph_pkg::STORE_HOLD_CYC,
   parameter int unsigned NV_WRITE   = tph_pkg::NV_WRITE_CYC
) (
   // clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   // PLC discrete inputs
   input  wire tph_pkg::tph_in_t i_pio,
   // controller-internal alarm and emergency stop levels
   input  wire logic             i_alarm_event,
   input  wire logic             i_estop_active,
   // PLC discrete outputs and servo enable
   output var  tph_pkg::tph_out_t o_pio,
   output logic                  o_servo_on,
   output logic [15:0]           o_position
);
   import tph_pkg::*;

   tph_in_t                sync1;
   tph_in_t                sync2;
   tph_in_t                prev;
   tph_state_t             state;
   logic [POS_W-1:0]       pos;
   logic [POS_W-1:0]       target;
   logic [POS_W-1:0]       inch_goal;
   logic [POS_W-1:0]       zone_lo;
   logic [POS_W-1:0]       zone_hi;
   logic [POS_W-1:0]       tbl_pos [0:(1<<IDX_W)-1];
   logic [POS_W-1:0]       tbl_zlo [0:(1<<IDX_W)-1];
   logic [POS_W-1:0]       tbl_zhi [0:(1<<IDX_W)-1];
   logic [IDX_W-1:0]       cmd_idx;
   logic [1:0]             step_cnt;
   logic [31:0]            hold_cnt;
   logic [31:0]            nv_cnt;
   logic                   nv_busy;
   logic                   store_fired;
   logic                   alarm;
   logic                   zone_valid;
   logic                   jog_dir_plus;
   logic                   pos_done;
   logic                   homed;
   logic                   rise_go;
   logic                   rise_home;
   logic                   rise_clr;
   logic                   rise_plus;
   logic                   rise_minus;
   logic                   ready;
   logic                   can_move;
   logic                   step_tick;
   logic [POS_W-1:0]       goal;
   logic                   at_goal;
   logic [POS_W-1:0]       next_pos;
   logic [POS_W-1:0]       pos_err;

   // two-flop synchroniser plus one stage for edge detection
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else begin
         sync1 <= i_pio;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   // rising edges of the synchronised command lines
   assign rise_go    = sync2.go_pulse    & ~prev.go_pulse;
   assign rise_home  = sync2.home        & ~prev.home;
   assign rise_clr   = sync2.fault_clear & ~prev.fault_clear;
   assign rise_plus  = sync2.jog_plus    & ~prev.jog_plus;
   assign rise_minus = sync2.jog_minus   & ~prev.jog_minus;

   // readiness and motion permission
   assign ready     = sync2.drive_energize & ~alarm & ~i_estop_active;
   assign can_move  = ready & sync2.pause_n;
   assign step_tick = (step_cnt == 2'(STEP_DIV_CYC - 1));

   // goal of the current motion and whether it is reached
   always_comb begin
      goal = target;
      case (state)
         ST_HOME: goal = '0;
         ST_INCH: goal = inch_goal;
         ST_JOG:  goal = jog_dir_plus ? {POS_W{1'b1}} : '0;
         default: goal = target;
      endcase
      at_goal = (pos == goal);
      if (pos < goal) begin
         next_pos = pos + 1'b1;
      end else if (pos > goal) begin
         next_pos = pos - 1'b1;
      end else begin
         next_pos = pos;
      end
      pos_err = (pos > target) ? pos - target : target - pos;
   end

   // step rate divider, runs only while motion is allowed
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !can_move || state == ST_IDLE) begin
         step_cnt <= '0;
      end else begin
         step_cnt <= step_tick ? 2'd0 : step_cnt + 2'd1;
      end
   end

   // alarm latch: a new alarm wins over a clear in the same cycle
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         alarm <= 1'b0;
      end else if (i_alarm_event) begin
         alarm <= 1'b1;
      end else if (rise_clr) begin
         alarm <= 1'b0;
      end
   end

   // motion state machine
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state        <= ST_IDLE;
         pos          <= POS_RST;
         target       <= POS_RST;
         inch_goal    <= POS_RST;
         cmd_idx      <= IDX_RST;
         jog_dir_plus <= 1'b0;
         pos_done     <= 1'b0;
         homed        <= 1'b0;
      end else if (!ready) begin
         state <= ST_IDLE;                                 // servo off or fault halts motion
      end else begin
         // idle never steps: a divider tick left from a stopped jog must not move
         if (can_move && step_tick && state != ST_IDLE) begin
            pos <= next_pos;
         end
         if (rise_go) begin
            state    <= ST_POS;
            target   <= tbl_pos[sync2.target_index];
            cmd_idx  <= sync2.target_index;
            pos_done <= 1'b0;
         end else if (rise_home) begin
            state    <= ST_HOME;
            pos_done <= 1'b0;
         end else if ((rise_plus || rise_minus) && sync2.teach_select) begin
            jog_dir_plus <= rise_plus;
            pos_done     <= 1'b0;
            if (sync2.jog_step_select) begin
               state     <= ST_INCH;
               inch_goal <= rise_plus ? pos + POS_W'(INCH_STEP) : pos - POS_W'(INCH_STEP);
            end else begin
               state <= ST_JOG;
            end
         end else begin
            case (state)
               ST_POS: begin
                  if (at_goal) begin
                     state    <= ST_IDLE;
                     pos_done <= 1'b1;
                  end
               end
               ST_HOME: begin
                  if (at_goal) begin
                     state <= ST_IDLE;
                     homed <= 1'b1;
                  end
               end
               ST_JOG: begin
                  // jog runs while its button is held
                  if ((jog_dir_plus && !sync2.jog_plus) || (!jog_dir_plus && !sync2.jog_minus)
                      || at_goal) begin
                     state <= ST_IDLE;
                  end
               end
               ST_INCH: begin
                  if (at_goal) begin
                     state <= ST_IDLE;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // zone limits of the commanded entry, valid from the first go
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         zone_valid <= 1'b0;
         zone_lo    <= '0;
         zone_hi    <= '0;
      end else if (rise_go && ready) begin
         zone_valid <= 1'b1;
         zone_lo    <= tbl_zlo[sync2.target_index];
         zone_hi    <= tbl_zhi[sync2.target_index];
      end
   end

   // store-here hold timer and modelled nonvolatile write
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         hold_cnt    <= '0;
         store_fired <= 1'b0;
         nv_busy     <= 1'b0;
         nv_cnt      <= '0;
      end else begin
         if (!sync2.store_here) begin
            hold_cnt    <= '0;
            store_fired <= 1'b0;
         end else if (hold_cnt != STORE_HOLD - 1) begin
            hold_cnt <= hold_cnt + 32'd1;
         end else if (!store_fired) begin
            store_fired <= 1'b1;
            nv_busy     <= 1'b1;
            nv_cnt      <= '0;
         end
         if (nv_busy) begin
            if (nv_cnt == NV_WRITE - 1) begin
               nv_busy <= 1'b0;
            end else begin
               nv_cnt <= nv_cnt + 32'd1;
            end
         end
      end
   end

   // position table: saved on the hold-time expiry
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < (1 << IDX_W); i++) begin
            tbl_pos[i] <= POS_RST;
            tbl_zlo[i] <= POS_RST - POS_W'(ZONE_HALF);
            tbl_zhi[i] <= POS_RST + POS_W'(ZONE_HALF);
         end
      end else if (sync2.store_here && hold_cnt == STORE_HOLD - 1 && !store_fired) begin
         tbl_pos[sync2.target_index] <= pos;
         tbl_zlo[sync2.target_index] <= pos - POS_W'(ZONE_HALF);
         tbl_zhi[sync2.target_index] <= pos + POS_W'(ZONE_HALF);
      end
   end

   // registered outputs toward the PLC
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_pio         <= '0;
         o_pio.estop_n <= 1'b1;
         o_pio.fault_n <= 1'b1;
         o_servo_on    <= 1'b0;
         o_position    <= POS_RST;
      end else begin
         if (rise_go) begin
            o_pio.reached_index <= '0;
         end else if (state == ST_POS && ready && at_goal) begin
            o_pio.reached_index <= cmd_idx;
         end
         o_pio.moving              <= can_move && state != ST_IDLE && !at_goal;
         o_pio.teach_state_out     <= sync2.teach_select;
         o_pio.window_hit          <= zone_valid && pos >= zone_lo && pos <= zone_hi;
         o_pio.remote_manual_state <= sync2.remote_manual_select;
         o_pio.homing_done         <= homed;
         o_pio.arrival_flag        <= pos_done && pos_err <= POS_W'(INPOS_BAND);
         o_pio.store_done          <= store_fired && !nv_busy;
         o_pio.drive_prepared      <= ready;
         o_pio.estop_n             <= ~i_estop_active;
         o_pio.fault_n             <= ~alarm;
         o_servo_on                <= sync2.drive_energize;
         o_position                <= pos;
      end
   end

endmodule : tph_handshake

`default_nettype wire

// ### bench/tph_plc_model.sv
// plc model: presents the target index, then raises go after a setup time
// assumes the bench raises i_req for one cycle; requests are taken at the rising
// edge and the device lines change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tph_plc_model #(
   parameter int unsigned SETUP = tph_pkg::CLK_HZ / 1000 * 6
) (
   // clock
   input  wire logic       i_mclk,
   // request from the bench
   input  wire logic       i_req,
   input  wire logic       i_fire,
   input  wire logic [5:0] i_idx,
   // lines to the device
   output logic [5:0]      o_idx,
   output logic            o_go
);
   int unsigned cnt   = 0;
   logic [5:0]  idx_q = 6'h00;
   initial o_idx = 6'h00;
   initial o_go = 1'b0;
   // take the bench request at the rising edge, where it is settled
   always @(posedge i_mclk) begin
      if (i_req) begin
         idx_q <= i_idx;
         cnt   <= i_fire ? SETUP + 4 : 0;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   // index first, go high for four cycles once the setup time ran out
   always @(negedge i_mclk) begin
      o_idx <= idx_q;
      o_go  <= (cnt != 0) && (cnt <= 4);
   end
endmodule : tph_plc_model
`default_nettype wire

// ### bench/tph_handshake_monitor.sv
// checker for the discrete handshake, sees only the top ports
// assumes bind onto tph_handshake with its parameters handed on
`timescale 1ns/1ps
`default_nettype none
module tph_handshake_monitor
   import tph_pkg::*;
#(
   parameter int unsigned STORE_HOLD = STORE_HOLD_CYC,
   parameter int unsigned NV_WRITE   = NV_WRITE_CYC
) (
   input wire logic        i_mclk,
   input wire logic        i_sys_rst,
   input wire tph_in_t     i_pio,
   input wire logic        i_alarm_event,
   input wire logic        i_estop_active,
   input wire tph_out_t    o_pio,
   input wire logic        o_servo_on,
   input wire logic [15:0] o_position
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   logic [31:0] held;
   // cycles that store-here has stayed high
   always_ff @(posedge i_mclk)
      held <= (i_sys_rst || !i_pio.store_here) ? 32'h0 : held + 32'h1;
   property p_servo; $rose(i_pio.drive_energize) |-> ##[1:4] o_servo_on; endproperty
   a_servo: assert property (p_servo) else $error("servo late");
   property p_teach;
      $stable(i_pio.teach_select) [*5] |-> o_pio.teach_state_out == i_pio.teach_select;
   endproperty
   a_teach: assert property (p_teach) else $error("teach state wrong");
   property p_remote;
      $stable(i_pio.remote_manual_select) [*5]
         |-> o_pio.remote_manual_state == i_pio.remote_manual_select;
   endproperty
   a_remote: assert property (p_remote) else $error("mode state wrong");
   property p_pause; !i_pio.pause_n [*5] |-> !o_pio.moving && $stable(o_position); endproperty
   a_pause: assert property (p_pause) else $error("moves in pause");
   property p_clear;
      $rose(i_pio.go_pulse) && o_pio.drive_prepared |-> ##[2:5] o_pio.reached_index == 6'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("index not cleared");
   property p_fault; i_alarm_event |-> ##[1:4] !o_pio.fault_n; endproperty
   a_fault: assert property (p_fault) else $error("fault missed");
   property p_estop; i_estop_active |-> ##[1:4] !o_pio.estop_n; endproperty
   a_estop: assert property (p_estop) else $error("estop missed");
   property p_prep; !i_pio.drive_energize [*5] |-> !o_pio.drive_prepared; endproperty
   a_prep: assert property (p_prep) else $error("ready without servo");
   property p_arrive; $rose(o_pio.arrival_flag) |-> !o_pio.moving; endproperty
   a_arrive: assert property (p_arrive) else $error("arrival while moving");
   property p_homed; $rose(o_pio.homing_done) |-> o_position == 16'h0000; endproperty
   a_homed: assert property (p_homed) else $error("homed off zero");
   property p_store; $rose(o_pio.store_done) |-> held >= STORE_HOLD + NV_WRITE; endproperty
   a_store: assert property (p_store) else $error("store done early");
   c_arrive: cover property ($rose(o_pio.arrival_flag));
   c_store: cover property ($rose(o_pio.store_done));
   c_home: cover property ($rose(o_pio.homing_done));
endmodule : tph_handshake_monitor
bind tph_handshake tph_handshake_monitor #(.STORE_HOLD(STORE_HOLD), .NV_WRITE(NV_WRITE))
   u_tph_handshake_monitor (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_pio(i_pio),
   .i_alarm_event(i_alarm_event), .i_estop_active(i_estop_active), .o_pio(o_pio),
   .o_servo_on(o_servo_on), .o_position(o_position));
`default_nettype wire

// ### bench/tph_handshake_tb.sv
// testbench: plc model for index and go, bench drives the other lines
// assumes shortened store and write counts and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tph_handshake_tb;
   import tph_pkg::*;
   logic        i_mclk = 1'b0;
   logic        i_sys_rst = 1'b1;
   tph_in_t     ctl = '0;
   tph_in_t     pio;
   logic        alarm = 1'b0;
   logic        estop = 1'b0;
   logic        req = 1'b0;
   logic        fire = 1'b0;
   logic [5:0]  req_idx = 6'h00;
   logic [5:0]  plc_idx;
   logic        plc_go;
   tph_out_t    o_pio;
   logic        servo;
   logic [15:0] pos;
   logic [15:0] p;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          k;
   // 50 ns clock
   always #25 i_mclk = ~i_mclk;
   assign pio = {plc_idx, plc_go, ctl[9:0]};
   tph_handshake #(.STORE_HOLD(50), .NV_WRITE(8)) u_tph_handshake (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .i_pio(pio), .i_alarm_event(alarm), .i_estop_active(estop),
      .o_pio(o_pio), .o_servo_on(servo), .o_position(pos));
   tph_plc_model #(.SETUP(10)) u_tph_plc_model (.i_mclk(i_mclk), .i_req(req), .i_fire(fire),
      .i_idx(req_idx), .o_idx(plc_idx), .o_go(plc_go));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge i_mclk);
   endtask : tick
   task automatic go_to(input logic [5:0] idx, input logic f);
      req_idx = idx;
      fire = f;
      req = 1'b1;
      tick(1);
      req = 1'b0;
      tick(16);
   endtask : go_to
   task automatic wait_on(input int b, input int lim);
      for (k = 0; k < lim && o_pio[b] !== 1'b1; k++) tick(1);
   endtask : wait_on
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // hang guard
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         tally_and_finish;
      end
   end
   // main sequence
   initial begin
      ctl.pause_n = 1'b1;
      tick(12);
      i_sys_rst = 1'b0;
      tick(2);
      chk(o_pio, 16'h0003);
      chk(pos, 16'h0400);
      ctl.drive_energize = 1'b1;
      tick(6);
      chk({servo, o_pio.drive_prepared}, 16'h0003);
      for (int m = 0; m < 4; m++) begin
         ctl.teach_select = m[0];
         ctl.remote_manual_select = m[1];
         tick(6);
         chk({o_pio.teach_state_out, o_pio.remote_manual_state}, {m[0], m[1]});
      end
      ctl.remote_manual_select = 1'b0;
      $display("test teach_state_out done");
      ctl.jog_step_select = 1'b1;
      ctl.jog_plus = 1'b1;
      tick(2);
      ctl.jog_plus = 1'b0;
      tick(80);
      chk(pos, 16'h0410);
      go_to(6'h05, 1'b0);
      ctl.store_here = 1'b1;
      wait_on(3, 300);
      chk(16'(k >= 50), 16'h0001);
      chk(o_pio.store_done, 16'h0001);
      ctl.store_here = 1'b0;
      ctl.jog_minus = 1'b1;
      tick(2);
      ctl.jog_minus = 1'b0;
      tick(80);
      chk(pos, 16'h0400);
      ctl.jog_step_select = 1'b0;
      ctl.jog_plus = 1'b1;
      tick(40);
      chk(o_pio.moving, 16'h0001);
      ctl.jog_plus = 1'b0;
      tick(6);
      p = pos;
      chk(16'(pos > 16'h0400), 16'h0001);
      chk(o_pio.moving, 16'h0000);
      tick(8);
      chk(pos, p);
      $display("test teach done");
      ctl.teach_select = 1'b0;
      go_to(6'h05, 1'b1);
      chk(o_pio.moving, 16'h0001);
      ctl.pause_n = 1'b0;
      tick(6);
      p = pos;
      tick(20);
      chk(o_pio.moving, 16'h0000);
      chk(pos, p);
      ctl.pause_n = 1'b1;
      wait_on(4, 600);
      chk(o_pio.arrival_flag, 16'h0001);
      chk({o_pio.reached_index, o_pio.window_hit}, 16'h000b);
      chk(pos, 16'h0410);
      go_to(6'h00, 1'b1);
      chk({o_pio.reached_index, o_pio.moving}, 16'h0001);
      wait_on(4, 600);
      chk(o_pio.arrival_flag, 16'h0001);
      chk(pos, 16'h0400);
      $display("test positioning done");
      ctl.home = 1'b1;
      tick(2);
      ctl.home = 1'b0;
      wait_on(5, 6000);
      chk(o_pio.homing_done, 16'h0001);
      chk(pos, 16'h0000);
      chk(o_pio.window_hit, 16'h0000);
      alarm = 1'b1;
      tick(1);
      alarm = 1'b0;
      tick(5);
      chk({o_pio.fault_n, o_pio.drive_prepared}, 16'h0000);
      ctl.fault_clear = 1'b1;
      tick(6);
      chk(o_pio.fault_n, 16'h0001);
      estop = 1'b1;
      tick(6);
      chk(o_pio.estop_n, 16'h0000);
      estop = 1'b0;
      ctl.drive_energize = 1'b0;
      tick(6);
      chk({o_pio.estop_n, servo, o_pio.drive_prepared}, 16'h0004);
      $display("test faults done");
      tally_and_finish;
   end
endmodule : tph_handshake_tb
`default_nettype wire
